// *** dft_pkg.sv ***
package dft_pkg;

  // ------------------------------------------------------------
  // trip indices
  // ------------------------------------------------------------
  localparam int TRIP_COUNT        = 16;
  localparam int IDX_OVERCURRENT   = 0;
  localparam int IDX_GROUND        = 1;
  localparam int IDX_OVERVOLT      = 2;
  localparam int IDX_CHARGE        = 3;
  localparam int IDX_SENSOR        = 4;
  localparam int IDX_OVERHEAT      = 5;
  localparam int IDX_PHASE_LOSS    = 6;
  localparam int IDX_DRIVE_OVLD    = 7;
  localparam int IDX_MOTOR_THERM   = 8;
  localparam int IDX_MOTOR_OVLD    = 9;
  localparam int IDX_EXT_NO        = 10;
  localparam int IDX_EXT_NC        = 11;
  localparam int IDX_LINK          = 12;
  localparam int IDX_IO_BOARD      = 13;
  localparam int IDX_BRAKE         = 14;
  localparam int IDX_UNDERVOLT     = 15;

  // ------------------------------------------------------------
  // register offsets (byte address = 4 * word index)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONFIG  = 8'h04;
  localparam logic [7:0] ADDR_BRAKE   = 8'h08;
  localparam logic [7:0] ADDR_ACTIVE  = 8'h0C;
  localparam logic [7:0] ADDR_LEVELS  = 8'h10;

  // config field positions
  localparam int CFG_OVLD_SEL_LSB  = 0;   // overload_trip_select, 8 bits
  localparam int CFG_THERM_SEL_LSB = 8;   // thermal_protect_select, 8 bits
  localparam int CFG_PHASE_SEL_LSB = 16;  // phase_loss_select, 4 bits
  localparam int CFG_RELAY1_LSB    = 20;  // relay1_output_function, 5 bits
  localparam int CFG_RELAY2_LSB    = 25;  // relay2_output_function, 5 bits
  localparam int CFG_EXT_SRC_BIT   = 30;  // 1 = source wiring
  localparam int PHASE_EN_BIT      = 1;
  localparam logic [4:0] RELAY_BRAKE_CODE = 5'h13;  // code 19
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [15:0] BRAKE_RESET  = 16'h0000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ            = 25_000_000;
  localparam int LINK_LOSS_MS      = 500;
  localparam int IO_LOSS_MS        = 2000;
  localparam int RECHARGE_MS       = 1000;
  localparam int LINK_LOSS_CYCLES  = (CLK_HZ / 1000) * LINK_LOSS_MS;
  localparam int IO_LOSS_CYCLES    = (CLK_HZ / 1000) * IO_LOSS_MS;
  localparam int RECHARGE_CYCLES   = (CLK_HZ / 1000) * RECHARGE_MS;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        motor_load_over;
    logic        current_over_200;
    logic        dc_over;
    logic        dc_under;
    logic        ground_over;
    logic        motor_thermal_over;
    logic [2:0]  phase_open;
    logic        drive_thermal_over;
    logic        power_unstable;
    logic        charge_fail;
    logic        heatsink_over;
    logic        temp_sensor_err;
    logic        fan_err;
    logic        ext_no_in;
    logic        ext_nc_in;
    logic        ext_no_assigned;
    logic        ext_nc_assigned;
    logic        link_alive;
    logic        io_link_alive;
    logic [15:0] output_current;
  } dft_sense_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dft_bus_t;

  typedef enum logic [1:0] { ST_IDLE, ST_TRIPPED, ST_FATAL } dft_mode_t;

  typedef struct packed {
    logic [TRIP_COUNT-1:0] trips;
    logic [31:0]           config_reg;
    logic [15:0]           brake_level;
    logic [31:0]           rdata;
    logic [31:0]           link_cnt;
    logic [31:0]           io_cnt;
    logic [31:0]           under_cnt;
    logic                  io_seen;
    logic                  under_recent;
    logic [4:0]            top_code;
    dft_mode_t             mode;
  } dft_state_t;

  // lowest raised index wins; 1F means nothing is raised
  function automatic logic [4:0] dft_prio(input logic [TRIP_COUNT-1:0] t);
    logic [4:0] code;
    code = 5'h1F;
    for (int i = TRIP_COUNT - 1; i >= 0; i--)
    begin
      if (t[i])
        code = 5'(i);
    end
    return code;
  endfunction

endpackage

// *** dft_plant_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// sensing circuits, trip terminals and reset key of the drive
// ------------------------------------------------------------
module dft_plant_model (
  input  wire logic           clk,
  output dft_pkg::dft_sense_t sense,
  output logic                trip_reset
);
  import dft_pkg::*;

  // idle terminals in sink wiring: open contact high, closed contact low
  localparam dft_sense_t IDLE = '{ext_no_in: 1'b1, ext_nc_in: 1'b0,
                                  ext_no_assigned: 1'b1, ext_nc_assigned: 1'b1,
                                  link_alive: 1'b1, output_current: 16'd200,
                                  default: '0};

  // io board silent at power-up, so that trip is seen first
  initial
  begin
    sense = IDLE;
    trip_reset = 1'b0;
  end

  // new levels land just after an edge and hold until the next call
  task automatic apply(input dft_sense_t s);
    @(posedge clk);
    sense <= s;
  endtask

  // one-cycle reset key press from the operator side
  task automatic pulse_reset;
    @(posedge clk);
    trip_reset <= 1'b1;
    @(posedge clk);
    trip_reset <= 1'b0;
  endtask
endmodule

// *** dft_trip_monitor.sv ***
`timescale 1ns/1ps
// Overview of operation
// - motor overload trip latched when select nonzero
// - overcurrent trip latched above 200 percent
// - overvoltage trip latched on DC over
// - undervoltage trip follows DC under level
// - ground fault trip latched on flag
// - motor thermal trip latched when select nonzero
// - phase loss latched when select bit1
// - drive overload from 150 percent model
// - charge trip fatal on unstable or fail
// - charge trip on any recovery from DC under
// - heatsink overheat trip latched
// - temp sensor fault trip latched
// - fan trip held on ext NO bit until reset input
// - normally-open external trip on short
// - normally-closed external trip on open
// - link-loss trip after 500 ms silence
// - brake trip below release current
// - io board trip at power-up, 2s loss
// - level trips self-clear without history
// - latched trips held until reset input
// - fatal trips clear only at power cycle
// - report highest priority active trip
module dft_trip_monitor
  import dft_pkg::*;
#(
  parameter int LINK_LOSS_LIMIT = LINK_LOSS_CYCLES,
  parameter int IO_LOSS_LIMIT   = IO_LOSS_CYCLES,
  parameter int RECHARGE_LIMIT  = RECHARGE_CYCLES
)(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire dft_pkg::dft_sense_t sense,
  input  wire logic             trip_reset,
  input  wire dft_pkg::dft_bus_t   bus,
  output logic [31:0]           rdata,
  output logic                  drive_halt,
  output logic [4:0]            top_trip_code,
  output logic [15:0]           trip_status
);
  import dft_pkg::*;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // a zero limit would leave the silence timers unable to count
  if (LINK_LOSS_LIMIT < 1 || IO_LOSS_LIMIT < 1 || RECHARGE_LIMIT < 1)
  begin
    $error("timing limits must be at least one cycle");
  end

  dft_state_t st;
  dft_state_t next_st;
  logic [TRIP_COUNT-1:0] cause;
  logic [TRIP_COUNT-1:0] latch_mask;
  logic                  brake_active;
  logic                  ext_no_hit;
  logic                  ext_nc_hit;

  // ------------------------------------------------------------
  // cause decode
  // ------------------------------------------------------------
  // fatal charge and level undervoltage bits are excluded from the latch mask
  assign latch_mask = ~((16'h0001 << IDX_CHARGE) | (16'h0001 << IDX_UNDERVOLT));

  always_comb
  begin
    brake_active = (st.config_reg[CFG_RELAY1_LSB +: 5] == RELAY_BRAKE_CODE) ||
                   (st.config_reg[CFG_RELAY2_LSB +: 5] == RELAY_BRAKE_CODE);
    // sink wiring shorts to common read as low, source reads high
    ext_no_hit = sense.ext_no_assigned &&
                 (sense.ext_no_in == st.config_reg[CFG_EXT_SRC_BIT]);
    ext_nc_hit = sense.ext_nc_assigned &&
                 (sense.ext_nc_in != st.config_reg[CFG_EXT_SRC_BIT]);
    cause = '0;
    cause[IDX_MOTOR_OVLD]  = sense.motor_load_over &&
                             (st.config_reg[CFG_OVLD_SEL_LSB +: 8] != 8'h00);
    cause[IDX_OVERCURRENT] = sense.current_over_200;
    cause[IDX_OVERVOLT]    = sense.dc_over;
    cause[IDX_UNDERVOLT]   = sense.dc_under;
    cause[IDX_GROUND]      = sense.ground_over;
    cause[IDX_MOTOR_THERM] = sense.motor_thermal_over &&
                             (st.config_reg[CFG_THERM_SEL_LSB +: 8] != 8'h00);
    cause[IDX_PHASE_LOSS]  = (|sense.phase_open) &&
                             st.config_reg[CFG_PHASE_SEL_LSB + PHASE_EN_BIT];
    cause[IDX_DRIVE_OVLD]  = sense.drive_thermal_over;
    cause[IDX_CHARGE]      = sense.power_unstable || sense.charge_fail ||
                             (st.under_recent && !sense.dc_under);
    cause[IDX_OVERHEAT]    = sense.heatsink_over;
    cause[IDX_SENSOR]      = sense.temp_sensor_err;
    cause[IDX_EXT_NO]      = ext_no_hit || sense.fan_err;
    cause[IDX_EXT_NC]      = ext_nc_hit;
    cause[IDX_LINK]        = st.link_cnt >= 32'(LINK_LOSS_LIMIT);
    cause[IDX_IO_BOARD]    = (!st.io_seen && !sense.io_link_alive) ||
                             (st.io_cnt >= 32'(IO_LOSS_LIMIT));
    cause[IDX_BRAKE]       = brake_active &&
                             (sense.output_current < st.brake_level);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // link silence counters saturate so a long outage cannot wrap
    if (sense.link_alive)
      next_st.link_cnt = '0;
    else if (st.link_cnt < 32'(LINK_LOSS_LIMIT))
      next_st.link_cnt = st.link_cnt + 32'd1;
    if (sense.io_link_alive)
    begin
      next_st.io_cnt  = '0;
      next_st.io_seen = 1'b1;
    end
    else if (st.io_seen && st.io_cnt < 32'(IO_LOSS_LIMIT))
      next_st.io_cnt = st.io_cnt + 32'd1;
    // undervoltage recovery window for the recharge check
    if (sense.dc_under)
    begin
      next_st.under_cnt    = '0;
      next_st.under_recent = 1'b1;
    end
    else if (st.under_recent)
    begin
      next_st.under_cnt = st.under_cnt + 32'd1;
      if (st.under_cnt >= 32'(RECHARGE_LIMIT - 1))
        next_st.under_recent = 1'b0;
    end
    // latch trips hold until reset; new cause beats the reset
    if (trip_reset)
      next_st.trips = (st.trips & ~latch_mask) | cause;
    else
      next_st.trips = st.trips | cause;
    next_st.trips[IDX_UNDERVOLT] = cause[IDX_UNDERVOLT];
    // fan shares the normally-open external bit and holds it until the reset key
    if (!ext_no_hit && !sense.fan_err && trip_reset)
      next_st.trips[IDX_EXT_NO] = 1'b0;
    if (sense.fan_err)
      next_st.trips[IDX_EXT_NO] = 1'b1;
    else if (!ext_no_hit && !st.config_reg[31])
      next_st.trips[IDX_EXT_NO] = st.trips[IDX_EXT_NO] & ~trip_reset;
    next_st.trips[IDX_CHARGE] = st.trips[IDX_CHARGE] | cause[IDX_CHARGE];
    next_st.top_code = dft_prio(next_st.trips);
    case (st.mode)
      ST_IDLE:    if (|next_st.trips) next_st.mode = ST_TRIPPED;
      ST_TRIPPED:
      begin
        if (next_st.trips[IDX_CHARGE])
          next_st.mode = ST_FATAL;
        else if (!(|next_st.trips))
          next_st.mode = ST_IDLE;
      end
      ST_FATAL:   next_st.mode = ST_FATAL;
      default:    next_st.mode = ST_IDLE;
    endcase
    // register port
    next_st.rdata = '0;
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_CONFIG: next_st.config_reg  = bus.wdata;
        ADDR_BRAKE:  next_st.brake_level = bus.wdata[15:0];
        default:     next_st.config_reg  = next_st.config_reg;
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_STATUS: next_st.rdata = {16'h0000, st.trips};
        ADDR_CONFIG: next_st.rdata = st.config_reg;
        ADDR_BRAKE:  next_st.rdata = {16'h0000, st.brake_level};
        ADDR_ACTIVE: next_st.rdata = {25'h000_0000, st.mode, st.top_code};
        ADDR_LEVELS: next_st.rdata = {16'h0000, cause};
        default:     next_st.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register; power-on reset is the only fatal clear
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st.trips        <= '0;
      st.config_reg   <= CONFIG_RESET;
      st.brake_level  <= BRAKE_RESET;
      st.rdata        <= '0;
      st.link_cnt     <= '0;
      st.io_cnt       <= '0;
      st.under_cnt    <= '0;
      st.io_seen      <= 1'b0;
      st.under_recent <= 1'b0;
      st.top_code     <= 5'h1F;
      st.mode         <= ST_IDLE;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata         = st.rdata;
  assign drive_halt    = |st.trips;
  assign top_trip_code = st.top_code;
  assign trip_status   = st.trips;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_overcurrent;
    @(posedge clk) disable iff (sys_rst)
      sense.current_over_200 |=> trip_status[IDX_OVERCURRENT];
  endproperty
  a_overcurrent: assert property (p_overcurrent) else $error("overcurrent not latched");

  property p_overload_gate;
    @(posedge clk) disable iff (sys_rst)
      (sense.motor_load_over && st.config_reg[7:0] == 8'h00 && !st.trips[IDX_MOTOR_OVLD])
      |=> !trip_status[IDX_MOTOR_OVLD];
  endproperty
  a_overload_gate: assert property (p_overload_gate) else $error("overload ungated");

  property p_under_level;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> trip_status[IDX_UNDERVOLT] == $past(sense.dc_under);
  endproperty
  a_under_level: assert property (p_under_level) else $error("undervoltage not level");

  property p_latch_hold;
    @(posedge clk) disable iff (sys_rst)
      (trip_status[IDX_OVERVOLT] && !trip_reset) |=> trip_status[IDX_OVERVOLT];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

  property p_fatal_hold;
    @(posedge clk) disable iff (sys_rst)
      trip_status[IDX_CHARGE] |=> trip_status[IDX_CHARGE] && st.mode == ST_FATAL;
  endproperty
  a_fatal_hold: assert property (p_fatal_hold) else $error("fatal cleared");

  property p_halt;
    @(posedge clk) disable iff (sys_rst)
      (|cause) |=> drive_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("halt mismatch");

  property p_link;
    @(posedge clk) disable iff (sys_rst)
      (st.link_cnt == 32'(LINK_LOSS_LIMIT - 1) && !sense.link_alive)
      |=> ##1 trip_status[IDX_LINK];
  endproperty
  a_link: assert property (p_link) else $error("link loss late");

  property p_prio;
    @(posedge clk) disable iff (sys_rst)
      trip_status[IDX_OVERCURRENT] |-> top_trip_code == 5'h00;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  property p_read;
    @(posedge clk) disable iff (sys_rst)
      (bus.rd && bus.addr == ADDR_STATUS) |=> rdata == {16'h0000, $past(st.trips)};
  endproperty
  a_read: assert property (p_read) else $error("status read wrong");

  c_trip:  cover property (@(posedge clk) disable iff (sys_rst) $rose(drive_halt));
  c_clear: cover property (@(posedge clk) disable iff (sys_rst) $fell(drive_halt));
  c_fatal: cover property (@(posedge clk) disable iff (sys_rst) st.mode == ST_FATAL);

endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import dft_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  dft_bus_t    bus = '0;
  dft_sense_t  sense;
  dft_sense_t  sv;
  logic        trip_reset;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        drive_halt;
  logic [4:0]  top_trip_code;
  logic [15:0] trip_status;
  int          fails = 0;
  int          n_compared = 0;
  // plain latched trips walked through raise, hold and key clear
  int          latch_ids[8] = '{0, 1, 2, 4, 5, 7, 10, 11};

  // 25 MHz
  always #20 clk = ~clk;

  dft_plant_model pm_u (.clk(clk), .sense(sense), .trip_reset(trip_reset));

  // short timers keep the run small: 20/40/30 cycles
  dft_trip_monitor #(.LINK_LOSS_LIMIT(20), .IO_LOSS_LIMIT(40), .RECHARGE_LIMIT(30)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .sense(sense), .trip_reset(trip_reset), .bus(bus),
    .rdata(rdata), .drive_halt(drive_halt), .top_trip_code(top_trip_code),
    .trip_status(trip_status));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("mismatches %0d of %0d compares", fails, n_compared);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // cause lands after one edge, status one edge later; halt follows status
  task automatic chk(input logic [15:0] exp);
    settle(2);
    cmp({16'h0000, trip_status}, {16'h0000, exp}, "status");
    cmp({31'h0, drive_halt}, {31'h0, |exp}, "halt");
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  // raise or drop one cause, in the sense that trips it
  task automatic set_cause(input int idx, input logic v);
    case (idx)
      0: sv.current_over_200 = v;
      1: sv.ground_over = v;
      2: sv.dc_over = v;
      3: sv.charge_fail = v;
      4: sv.temp_sensor_err = v;
      5: sv.heatsink_over = v;
      6: sv.phase_open[0] = v;
      7: sv.drive_thermal_over = v;
      8: sv.motor_thermal_over = v;
      9: sv.motor_load_over = v;
      10: sv.ext_no_in = ~v;
      11: sv.ext_nc_in = v;
      12: sv.link_alive = ~v;
      13: sv.io_link_alive = ~v;
      14: sv.output_current = v ? 16'd50 : 16'd200;
      default: sv.dc_under = v;
    endcase
    pm_u.apply(sv);
  endtask

  // bounded wait for one trip bit; running out ends the run
  task automatic wait_bit(input int idx, input int lim);
    int k;
    for (k = 0; k < lim && trip_status[idx] !== 1'b1; k++)
      settle(1);
    if (k == lim)
    begin
      fails++;
      $display("MISMATCH %0t trip %0d never rose", $time, idx);
      finish_test();
    end
  endtask

  // raise, drop the cause, see it held, clear with the key
  task automatic latch_cycle(input int i);
    set_cause(i, 1'b1);
    chk(16'(1 << i));
    set_cause(i, 1'b0);
    chk(16'(1 << i));
    pm_u.pulse_reset();
    chk(16'h0000);
  endtask

  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_power_up;
    settle(2);
    cmp({16'h0000, trip_status}, 32'h0000_2000, "io at power-up");
    cmp({27'h0, top_trip_code}, 32'd13, "code io");
    bus_rd(ADDR_CONFIG, rv);
    cmp(rv, CONFIG_RESET, "config reset");
    bus_rd(ADDR_BRAKE, rv);
    cmp(rv, {16'h0000, BRAKE_RESET}, "brake reset");
    set_cause(13, 1'b0);
    pm_u.pulse_reset();
    chk(16'h0000);
    cmp({27'h0, top_trip_code}, 32'h0000_001F, "code idle");
  endtask

  task automatic t_gated;
    int gated[3] = '{9, 8, 6};
    bus_wr(ADDR_CONFIG, 32'h0001_0000);
    foreach (gated[j])
    begin
      set_cause(gated[j], 1'b1);
      chk(16'h0000);
      set_cause(gated[j], 1'b0);
    end
    bus_wr(ADDR_CONFIG, 32'h0002_0101);
    foreach (gated[j])
      latch_cycle(gated[j]);
  endtask

  task automatic t_bus_prio;
    bus_wr(8'h40, 32'hFFFF_FFFF);
    bus_rd(8'h40, rv);
    cmp(rv, 32'h0000_0000, "unmapped");
    bus_rd(ADDR_CONFIG, rv);
    cmp(rv, 32'h0002_0101, "config kept");
    sv.heatsink_over = 1'b1;
    set_cause(2, 1'b1);
    chk(16'h0024);
    cmp({27'h0, top_trip_code}, 32'd2, "priority");
    bus_rd(ADDR_STATUS, rv);
    cmp(rv, 32'h0000_0024, "status read");
    bus_rd(ADDR_LEVELS, rv);
    cmp(rv, 32'h0000_0024, "live causes");
    sv.heatsink_over = 1'b0;
    set_cause(2, 1'b0);
    pm_u.pulse_reset();
    chk(16'h0000);
  endtask

  task automatic t_fan_brake;
    sv.fan_err = 1'b1;
    pm_u.apply(sv);
    chk(16'h0400);
    sv.fan_err = 1'b0;
    pm_u.apply(sv);
    pm_u.pulse_reset();
    chk(16'h0000);
    bus_wr(ADDR_BRAKE, 32'd100);
    set_cause(14, 1'b1);
    chk(16'h0000);
    set_cause(14, 1'b0);
    bus_wr(ADDR_CONFIG, 32'h0132_0101);
    latch_cycle(14);
  endtask

  task automatic t_links;
    sv.link_alive = 1'b0;
    set_cause(13, 1'b1);
    settle(14);
    cmp({16'h0000, trip_status}, 32'h0000_0000, "early link");
    wait_bit(12, 20);
    cmp({31'h0, trip_status[13]}, 32'h0, "early io");
    wait_bit(13, 40);
    sv.link_alive = 1'b1;
    set_cause(13, 1'b0);
    pm_u.pulse_reset();
    chk(16'h0000);
  endtask

  task automatic t_charge;
    set_cause(15, 1'b1);
    chk(16'h8000);
    set_cause(15, 1'b0);
    settle(2);
    cmp({31'h0, trip_status[15]}, 32'h0, "under self-clear");
    wait_bit(3, 40);
    pm_u.pulse_reset();
    settle(2);
    cmp({31'h0, trip_status[3]}, 32'h1, "fatal held");
    bus_rd(ADDR_ACTIVE, rv);
    cmp({30'h0, rv[6:5]}, {30'h0, ST_FATAL}, "fatal mode");
    do_reset();
    chk(16'h0000);
    set_cause(3, 1'b1);
    chk(16'h0008);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    sv = pm_u.IDLE;
    repeat (3) @(posedge clk);
    #1 cmp({27'h0, top_trip_code}, 32'h0000_001F, "code in reset");
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_power_up();
    foreach (latch_ids[j])
      latch_cycle(latch_ids[j]);
    t_gated();
    t_bus_prio();
    t_fan_brake();
    t_links();
    t_charge();
    finish_test();
  end
endmodule
